// [common/spe_pkg.sv]
// Constants for the serial port error handling block.
// Assumes a 50 MHz system clock and a word-wide register port.
package spe_pkg;
	localparam int SYS_CLK_HZ = 50000000;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int HW = 16;
	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_TX_LOW = 8'h08;
	localparam logic [7:0] OFS_TX_HIGH = 8'h0C;
	localparam logic [7:0] OFS_RX_LOW = 8'h10;
	localparam logic [7:0] OFS_RX_HIGH = 8'h14;
	// Control fields
	localparam int CB_RX_RESET_N = 0;
	localparam int CB_TX_RESET_N = 1;
	localparam int CB_RX_DELAY = 2;
	localparam int CB_TX_DELAY = 4;
	localparam int CB_RX_IRQ_MODE = 6;
	localparam int CB_TX_IRQ_MODE = 8;
	localparam int CB_RX_IGNORE = 10;
	localparam int CB_TX_IGNORE = 11;
	localparam int CB_TX_SRC_SEL = 12;
	localparam int CB_GEN_MODE = 13;
	localparam int CB_WIDE = 14;
	localparam int CTRL_W = 15;
	localparam logic [14:0] CTRL_RESET = 15'h0000;
	// Status fields
	localparam int SB_TX_READY = 0;
	localparam int SB_TX_EMPTY_N = 1;
	localparam int SB_TX_SYNC_ERR = 2;
	localparam int SB_RX_READY = 3;
	localparam int SB_RX_SYNC_ERR = 4;
	// Interrupt modes
	localparam logic [1:0] IRQ_MODE_READY = 2'h0;
	localparam logic [1:0] IRQ_MODE_SYNC_ERR = 2'h3;
	// Word lengths
	localparam logic [4:0] LAST_BIT_NARROW = 5'h0F;
	localparam logic [4:0] LAST_BIT_WIDE = 5'h1F;
	typedef enum logic [1:0] {SPE_IDLE, SPE_DELAY, SPE_SHIFT} spe_state_e;
endpackage : spe_pkg

// [core/spe_core.sv]
// Error handling core of a buffered synchronous serial port: transmit
// overwrite, underflow, first word after reset and unexpected frame syncs,
// receive unexpected frame syncs, status flags, interrupts, DMA event.
// Assumes link pins come from outside the sys_clk domain, bit clocks far
// slower than sys_clk, and a register master that never reads and writes
// in one cycle.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module spe_core (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic tx_bit_clock,
	input wire logic tx_frame_sync,
	output logic tx_frame_sync_out,
	output logic tx_frame_sync_oe,
	output logic tx_data_line,
	output logic tx_data_oe,
	input wire logic gen_frame_pulse,
	input wire logic rx_bit_clock,
	input wire logic rx_frame_sync,
	input wire logic rx_data_line,
	output logic tx_irq,
	output logic rx_irq,
	output logic tx_dma_event
);
	function automatic logic [4:0] last_bit(input logic wide);
		last_bit = wide ? spe_pkg::LAST_BIT_WIDE : spe_pkg::LAST_BIT_NARROW;
	endfunction : last_bit

	function automatic logic is_unexpected(input spe_pkg::spe_state_e st, input logic [4:0] idx,
		input logic [4:0] last);
		// Sync on the edge that ends the last bit still counts as between packets
		is_unexpected = (st == spe_pkg::SPE_DELAY) || ((st == spe_pkg::SPE_SHIFT) && (idx != last));
	endfunction : is_unexpected

	// Register port
	logic [14:0] ctrl_r;
	logic [15:0] tx_data_reg_low_r;
	logic [15:0] tx_data_reg_high_r;
	logic [15:0] rx_data_reg_low_r;
	logic [15:0] rx_data_reg_high_r;
	logic tx_ready_flag_r;
	logic tx_empty_n_r;
	logic tx_sync_error_flag_r;
	logic rx_ready_flag_r;
	logic rx_sync_error_flag_r;
	logic [31:0] reg_rdata_nxt;

	wire wr_ctrl = reg_wr && (reg_addr == spe_pkg::OFS_CTRL);
	wire wr_status = reg_wr && (reg_addr == spe_pkg::OFS_STATUS);
	wire wr_tx_low = reg_wr && (reg_addr == spe_pkg::OFS_TX_LOW);
	wire wr_tx_high = reg_wr && (reg_addr == spe_pkg::OFS_TX_HIGH);
	wire rd_rx_low = reg_rd && (reg_addr == spe_pkg::OFS_RX_LOW);

	wire rx_enable = ctrl_r[spe_pkg::CB_RX_RESET_N];
	wire tx_reset_n = ctrl_r[spe_pkg::CB_TX_RESET_N];
	wire [1:0] rx_data_delay = ctrl_r[spe_pkg::CB_RX_DELAY +: 2];
	wire [1:0] tx_data_delay = ctrl_r[spe_pkg::CB_TX_DELAY +: 2];
	wire [1:0] rx_irq_mode = ctrl_r[spe_pkg::CB_RX_IRQ_MODE +: 2];
	wire [1:0] tx_irq_mode = ctrl_r[spe_pkg::CB_TX_IRQ_MODE +: 2];
	wire rx_sync_ignore = ctrl_r[spe_pkg::CB_RX_IGNORE];
	wire tx_sync_ignore = ctrl_r[spe_pkg::CB_TX_IGNORE];
	wire tx_sync_source_sel = ctrl_r[spe_pkg::CB_TX_SRC_SEL];
	wire gen_sync_mode = ctrl_r[spe_pkg::CB_GEN_MODE];
	wire wide = ctrl_r[spe_pkg::CB_WIDE];
	wire [4:0] last = last_bit(wide);

	wire [4:0] status_word = {rx_sync_error_flag_r, rx_ready_flag_r, tx_sync_error_flag_r,
		tx_empty_n_r, tx_ready_flag_r};

	always_comb
	begin
		case (reg_addr)
			spe_pkg::OFS_CTRL: reg_rdata_nxt = {17'h00000, ctrl_r};
			spe_pkg::OFS_STATUS: reg_rdata_nxt = {27'h0000000, status_word};
			spe_pkg::OFS_TX_LOW: reg_rdata_nxt = {16'h0000, tx_data_reg_low_r};
			spe_pkg::OFS_TX_HIGH: reg_rdata_nxt = {16'h0000, tx_data_reg_high_r};
			spe_pkg::OFS_RX_LOW: reg_rdata_nxt = {16'h0000, rx_data_reg_low_r};
			spe_pkg::OFS_RX_HIGH: reg_rdata_nxt = {16'h0000, rx_data_reg_high_r};
			default: reg_rdata_nxt = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			reg_rdata <= 32'h00000000;
		else
			reg_rdata <= reg_rd ? reg_rdata_nxt : 32'h00000000;
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_r <= spe_pkg::CTRL_RESET;
			tx_data_reg_low_r <= 16'h0000;
			tx_data_reg_high_r <= 16'h0000;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= reg_wdata[14:0];
			if (wr_tx_low)
				tx_data_reg_low_r <= reg_wdata[15:0];
			if (wr_tx_high)
				tx_data_reg_high_r <= reg_wdata[15:0];
		end
	end

	// Link input synchronisers; stage one feeds stage two only
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic tx_clk_d_r;
	logic rx_clk_d_r;
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync1_r <= 5'h00;
			sync2_r <= 5'h00;
			tx_clk_d_r <= 1'b0;
			rx_clk_d_r <= 1'b0;
		end
		else
		begin
			sync1_r <= {rx_data_line, rx_frame_sync, rx_bit_clock, tx_frame_sync, tx_bit_clock};
			sync2_r <= sync1_r;
			tx_clk_d_r <= sync2_r[0];
			rx_clk_d_r <= sync2_r[2];
		end
	end
	wire tx_edge = sync2_r[0] && !tx_clk_d_r;
	// Last bit ends on its falling edge; the partner may stop its clock after it
	wire tx_fall = !sync2_r[0] && tx_clk_d_r;
	// Receiver samples on the falling edge, half a bit after the driver
	wire rx_edge = !sync2_r[2] && rx_clk_d_r;
	wire tx_fs_lvl = sync2_r[1];
	wire rx_fs_lvl = sync2_r[3];
	wire rx_bit = sync2_r[4];

	// Transmitter
	spe_pkg::spe_state_e tx_state_r;
	spe_pkg::spe_state_e tx_state_nxt;
	logic [15:0] tx_shift_low_r;
	logic [15:0] tx_shift_high_r;
	logic [4:0] tx_idx_r;
	logic [4:0] tx_idx_nxt;
	logic [1:0] tx_dly_r;
	logic [1:0] tx_dly_nxt;
	logic tx_dirty_r;
	logic tx_fs_prev_r;
	logic tx_gen_pend_r;
	logic tx_copy;
	logic tx_unexp;

	wire tx_ext_sync = tx_edge && tx_fs_lvl && !tx_fs_prev_r;
	wire tx_int_sync = tx_edge && tx_gen_pend_r;
	wire tx_sync = tx_reset_n && (tx_sync_source_sel ? tx_int_sync : tx_ext_sync);
	wire tx_busy_err = is_unexpected(tx_state_r, tx_idx_r, last);
	wire tx_frame_end = tx_fall && (tx_state_r == spe_pkg::SPE_SHIFT) && (tx_idx_r == last);

	always_comb
	begin
		tx_state_nxt = tx_state_r;
		tx_idx_nxt = tx_idx_r;
		tx_dly_nxt = tx_dly_r;
		tx_unexp = 1'b0;
		// Copy only while the shift register is free, or on a restart with a new word
		tx_copy = tx_reset_n && tx_dirty_r && (tx_state_r == spe_pkg::SPE_IDLE);
		if (tx_sync && tx_busy_err && !tx_sync_ignore)
		begin
			tx_unexp = 1'b1;
			tx_copy = tx_dirty_r;
		end
		if (tx_sync && (!tx_busy_err || !tx_sync_ignore))
		begin
			if (tx_data_delay == 2'h0)
			begin
				tx_state_nxt = spe_pkg::SPE_SHIFT;
				tx_idx_nxt = 5'h00;
			end
			else
			begin
				tx_state_nxt = spe_pkg::SPE_DELAY;
				tx_dly_nxt = tx_data_delay - 2'h1;
			end
		end
		else if (tx_edge && (tx_state_r == spe_pkg::SPE_DELAY))
		begin
			if (tx_dly_r == 2'h0)
			begin
				tx_state_nxt = spe_pkg::SPE_SHIFT;
				tx_idx_nxt = 5'h00;
			end
			else
				tx_dly_nxt = tx_dly_r - 2'h1;
		end
		else if (tx_edge && (tx_state_r == spe_pkg::SPE_SHIFT))
		begin
			if (tx_idx_r == last)
				tx_state_nxt = spe_pkg::SPE_IDLE;
			else
				tx_idx_nxt = tx_idx_r + 5'h01;
		end
		else if (tx_frame_end)
			tx_state_nxt = spe_pkg::SPE_IDLE;
		if (!tx_reset_n)
			tx_state_nxt = spe_pkg::SPE_IDLE;
	end

	// Word seen by the line: a copy in this cycle is already on its way out
	wire [31:0] tx_word = tx_copy ? {tx_data_reg_high_r, tx_data_reg_low_r}
		: {tx_shift_high_r, tx_shift_low_r};
	wire [4:0] tx_pos = last - tx_idx_nxt;
	wire tx_bit_nxt = (tx_state_nxt == spe_pkg::SPE_SHIFT) ? tx_word[tx_pos] : 1'b0;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_state_r <= spe_pkg::SPE_IDLE;
			tx_idx_r <= 5'h00;
			tx_dly_r <= 2'h0;
			tx_data_line <= 1'b0;
			tx_fs_prev_r <= 1'b0;
		end
		else
		begin
			tx_state_r <= tx_state_nxt;
			tx_idx_r <= tx_idx_nxt;
			tx_dly_r <= tx_dly_nxt;
			if (tx_edge)
			begin
				tx_data_line <= tx_bit_nxt;
				tx_fs_prev_r <= tx_fs_lvl;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_shift_low_r <= 16'h0000;
			tx_shift_high_r <= 16'h0000;
			tx_dirty_r <= 1'b0;
		end
		else if (!tx_reset_n)
		begin
			// Zeros go out if a sync beats the first load
			tx_shift_low_r <= 16'h0000;
			tx_shift_high_r <= 16'h0000;
			tx_dirty_r <= wr_tx_low;
		end
		else
		begin
			if (tx_copy)
			begin
				tx_shift_low_r <= tx_data_reg_low_r;
				tx_shift_high_r <= tx_data_reg_high_r;
			end
			// Without a new load the shift word stays and is resent
			tx_dirty_r <= wr_tx_low || (tx_dirty_r && !tx_copy);
		end
	end

	// Flags and events
	logic tx_reset_n_d_r;
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_reset_n_d_r <= 1'b0;
			tx_ready_flag_r <= 1'b1;
			tx_empty_n_r <= 1'b0;
			tx_sync_error_flag_r <= 1'b0;
			tx_dma_event <= 1'b0;
			tx_irq <= 1'b0;
		end
		else
		begin
			tx_reset_n_d_r <= tx_reset_n;
			tx_dma_event <= tx_copy;
			tx_irq <= (tx_copy && (tx_irq_mode == spe_pkg::IRQ_MODE_READY))
				|| (tx_unexp && (tx_irq_mode == spe_pkg::IRQ_MODE_SYNC_ERR));
			if (!tx_reset_n)
			begin
				tx_ready_flag_r <= 1'b1;
				tx_empty_n_r <= 1'b0;
				tx_sync_error_flag_r <= 1'b0;
			end
			else
			begin
				// Set wins over the clearing write
				if (tx_copy)
					tx_ready_flag_r <= 1'b1;
				else if (wr_tx_low)
					tx_ready_flag_r <= 1'b0;
				if (tx_copy)
					tx_empty_n_r <= 1'b1;
				else if (tx_frame_end && !tx_dirty_r)
					tx_empty_n_r <= 1'b0;
				if (tx_unexp)
					tx_sync_error_flag_r <= 1'b1;
				else if (wr_status && !reg_wdata[spe_pkg::SB_TX_SYNC_ERR])
					tx_sync_error_flag_r <= 1'b0;
			end
		end
	end

	// Internal frame sync: one pulse per copy, or paced by the rate generator
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_gen_pend_r <= 1'b0;
			tx_frame_sync_out <= 1'b0;
		end
		else if (!tx_reset_n || !tx_sync_source_sel)
		begin
			tx_gen_pend_r <= 1'b0;
			tx_frame_sync_out <= 1'b0;
		end
		else
		begin
			if (gen_sync_mode ? gen_frame_pulse : tx_copy)
				tx_gen_pend_r <= 1'b1;
			else if (tx_edge)
				tx_gen_pend_r <= 1'b0;
			if (tx_edge)
				tx_frame_sync_out <= tx_gen_pend_r;
		end
	end

	assign tx_frame_sync_oe = tx_sync_source_sel;
	assign tx_data_oe = tx_reset_n && tx_reset_n_d_r;

	// Receiver; the partner is expected to space syncs properly
	spe_pkg::spe_state_e rx_state_r;
	spe_pkg::spe_state_e rx_state_nxt;
	logic [4:0] rx_idx_r;
	logic [4:0] rx_idx_nxt;
	logic [1:0] rx_dly_r;
	logic [1:0] rx_dly_nxt;
	logic [31:0] rx_shift_r;
	logic rx_fs_prev_r;
	logic rx_unexp;
	logic rx_take;

	wire rx_sync = rx_enable && rx_edge && rx_fs_lvl && !rx_fs_prev_r;
	wire rx_busy_err = is_unexpected(rx_state_r, rx_idx_r, last);

	always_comb
	begin
		rx_state_nxt = rx_state_r;
		rx_idx_nxt = rx_idx_r;
		rx_dly_nxt = rx_dly_r;
		rx_unexp = 1'b0;
		rx_take = 1'b0;
		if (rx_sync && rx_busy_err && !rx_sync_ignore)
			rx_unexp = 1'b1;
		if (rx_sync && (!rx_busy_err || !rx_sync_ignore))
		begin
			// Aborted word is dropped, the new frame starts now
			if (rx_data_delay == 2'h0)
			begin
				rx_state_nxt = spe_pkg::SPE_SHIFT;
				rx_idx_nxt = 5'h00;
				rx_take = 1'b1;
			end
			else
			begin
				rx_state_nxt = spe_pkg::SPE_DELAY;
				rx_dly_nxt = rx_data_delay - 2'h1;
			end
		end
		else if (rx_edge && (rx_state_r == spe_pkg::SPE_DELAY))
		begin
			if (rx_dly_r == 2'h0)
			begin
				rx_state_nxt = spe_pkg::SPE_SHIFT;
				rx_idx_nxt = 5'h00;
				rx_take = 1'b1;
			end
			else
				rx_dly_nxt = rx_dly_r - 2'h1;
		end
		else if (rx_edge && (rx_state_r == spe_pkg::SPE_SHIFT))
		begin
			if (rx_idx_r == last)
				rx_state_nxt = spe_pkg::SPE_IDLE;
			else
			begin
				rx_idx_nxt = rx_idx_r + 5'h01;
				rx_take = 1'b1;
			end
		end
		if (!rx_enable)
			rx_state_nxt = spe_pkg::SPE_IDLE;
	end

	wire [31:0] rx_shift_nxt = {rx_shift_r[30:0], rx_bit};
	wire rx_word_done = rx_take && (rx_idx_nxt == last);

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_state_r <= spe_pkg::SPE_IDLE;
			rx_idx_r <= 5'h00;
			rx_dly_r <= 2'h0;
			rx_shift_r <= 32'h00000000;
			rx_fs_prev_r <= 1'b0;
			rx_data_reg_low_r <= 16'h0000;
			rx_data_reg_high_r <= 16'h0000;
		end
		else
		begin
			rx_state_r <= rx_state_nxt;
			rx_idx_r <= rx_idx_nxt;
			rx_dly_r <= rx_dly_nxt;
			if (rx_edge)
				rx_fs_prev_r <= rx_fs_lvl;
			if (rx_take)
				rx_shift_r <= rx_shift_nxt;
			if (rx_word_done)
			begin
				rx_data_reg_low_r <= rx_shift_nxt[15:0];
				rx_data_reg_high_r <= wide ? rx_shift_nxt[31:16] : 16'h0000;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_ready_flag_r <= 1'b0;
			rx_sync_error_flag_r <= 1'b0;
			rx_irq <= 1'b0;
		end
		else
		begin
			rx_irq <= (rx_word_done && (rx_irq_mode == spe_pkg::IRQ_MODE_READY))
				|| (rx_unexp && (rx_irq_mode == spe_pkg::IRQ_MODE_SYNC_ERR));
			if (!rx_enable)
			begin
				rx_ready_flag_r <= 1'b0;
				rx_sync_error_flag_r <= 1'b0;
			end
			else
			begin
				if (rx_word_done)
					rx_ready_flag_r <= 1'b1;
				else if (rd_rx_low)
					rx_ready_flag_r <= 1'b0;
				if (rx_unexp)
					rx_sync_error_flag_r <= 1'b1;
				else if (wr_status && !reg_wdata[spe_pkg::SB_RX_SYNC_ERR])
					rx_sync_error_flag_r <= 1'b0;
			end
		end
	end
endmodule : spe_core
`default_nettype wire

// [tb/spe_core_props.sv]
// Checker on the ports of the serial port error core, bound below.
// Assumes one-cycle strobes and the register map of spe_pkg.
`timescale 1ns/1ps
`default_nettype none
module spe_core_props (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic tx_bit_clock,
	input wire logic tx_frame_sync,
	input wire logic tx_frame_sync_out,
	input wire logic tx_frame_sync_oe,
	input wire logic tx_data_line,
	input wire logic tx_data_oe,
	input wire logic gen_frame_pulse,
	input wire logic rx_bit_clock,
	input wire logic rx_frame_sync,
	input wire logic rx_data_line,
	input wire logic tx_irq,
	input wire logic rx_irq,
	input wire logic tx_dma_event
);
	logic [14:0] ctrl_r;
	logic pend_r;
	wire logic wr_ct = reg_wr && reg_addr == spe_pkg::OFS_CTRL;
	wire logic wr_lo = reg_wr && reg_addr == spe_pkg::OFS_TX_LOW;
	wire logic map_w = reg_addr <= spe_pkg::OFS_RX_HIGH && reg_addr[1:0] == 2'h0;
	// Shadow of control and of a load not yet copied
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_r <= spe_pkg::CTRL_RESET;
			pend_r <= 1'h0;
		end
		else
		begin
			if (wr_ct)
				ctrl_r <= reg_wdata[14:0];
			pend_r <= wr_lo || (pend_r && !tx_dma_event);
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("stray read data");
	a_unmapped_read: assert property (reg_rd && !map_w |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_copy_needs_load: assert property (tx_dma_event |-> pend_r)
		else $error("copy without load");
	a_ready_irq: assert property (tx_dma_event && ctrl_r[9:8] == 2'h0 |-> tx_irq)
		else $error("no irq on ready");
	a_txirq_cause: assert property (tx_irq |-> ctrl_r[9:8] == 2'h3 || tx_dma_event)
		else $error("tx irq without cause");
	a_rxirq_mode: assert property (rx_irq |-> ctrl_r[7:6] inside {2'h0, 2'h3})
		else $error("rx irq in silent mode");
	a_rxirq_single: assert property (rx_irq |=> !rx_irq [*3])
		else $error("rx irq too long");
	a_sync_oe: assert property (ctrl_r[12] == $past(ctrl_r[12]) |-> tx_frame_sync_oe == ctrl_r[12])
		else $error("sync enable wrong");
	a_data_oe: assert property (ctrl_r[1] == $past(ctrl_r[1]) |-> tx_data_oe == ctrl_r[1])
		else $error("data enable wrong");
	a_quiet_reset: assert property (!ctrl_r[1] && !$past(ctrl_r[1]) |-> !tx_data_line)
		else $error("data line busy in reset");
	a_reset_status: assert property (!ctrl_r[1] && !$past(ctrl_r[1]) && $past(reg_rd)
		&& $past(reg_addr) == spe_pkg::OFS_STATUS |-> reg_rdata[2:0] == 3'h1)
		else $error("tx status wrong in reset");
	c_copy: cover property (tx_dma_event);
	c_tx_err_irq: cover property (tx_irq && ctrl_r[9:8] == 2'h3);
	c_rx_err_irq: cover property (rx_irq && ctrl_r[7:6] == 2'h3);
	c_int_sync: cover property (tx_frame_sync_out);
endmodule : spe_core_props
bind spe_core spe_core_props spe_core_props_i (
	.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.tx_bit_clock, .tx_frame_sync, .tx_frame_sync_out, .tx_frame_sync_oe,
	.tx_data_line, .tx_data_oe, .gen_frame_pulse, .rx_bit_clock,
	.rx_frame_sync, .rx_data_line, .tx_irq, .rx_irq, .tx_dma_event
);
`default_nettype wire

// [tb/spe_link_model.sv]
// Far-side serial device: bit clocks, frame syncs, receive data.
// Assumes the core finds link edges with its own clock.
`timescale 1ns/1ps
`default_nettype none
module spe_link_model (
	output logic tx_bit_clock,
	output logic tx_frame_sync,
	input wire logic tx_data_line,
	output logic rx_bit_clock,
	output logic rx_frame_sync,
	output logic rx_data_line
);
	initial
	begin
		tx_bit_clock = 1'h0;
		tx_frame_sync = 1'h0;
		rx_bit_clock = 1'h0;
		rx_frame_sync = 1'h0;
		rx_data_line = 1'h0;
	end
	// Clocks stand still between frames; 160 ns period inside
	// Sampling late in the low phase leaves margin for the resync delay
	task automatic tx_frame(input int n, input int s2, output logic [31:0] cap);
		cap = 32'h0;
		for (int i = 0; i < n; i++)
		begin
			#50 if (i > 0) cap = {cap[30:0], tx_data_line};
			if (i == s2) cap = 32'h0;
			tx_frame_sync = i == 0 || i == s2;
			#30 tx_bit_clock = 1'h1;
			#80 tx_bit_clock = 1'h0;
		end
		#50 cap = {cap[30:0], tx_data_line};
		tx_frame_sync = 1'h0;
	endtask : tx_frame
	task automatic rx_frame(input logic [15:0] w, input int s2, input int d);
		int k;
		for (int i = 0; i < s2 + 16 + d; i++)
		begin
			k = i - ((s2 > 0 && i >= s2) ? s2 : 0) - d;
			rx_frame_sync = i == 0 || (s2 > 0 && i == s2);
			rx_data_line = (k >= 0 && !(i < s2)) ? w[15 - k] : ~rx_data_line;
			#30 rx_bit_clock = 1'h1;
			#80 rx_bit_clock = 1'h0;
			#50;
		end
		rx_frame_sync = 1'h0;
		rx_data_line = ~rx_data_line;
		#80;
	endtask : rx_frame
endmodule : spe_link_model
`default_nettype wire

// [tb/tb_spe_core.sv]
// Self-checking bench for the serial port error core.
// Assumes the link model makes every link clock and every sync that the core does not drive itself.
`timescale 1ns/1ps
`default_nettype none
module tb_spe_core;
	localparam logic [7:0] A_CT = spe_pkg::OFS_CTRL;
	localparam logic [7:0] A_ST = spe_pkg::OFS_STATUS;
	localparam logic [7:0] A_TL = spe_pkg::OFS_TX_LOW;
	localparam logic [7:0] A_TH = spe_pkg::OFS_TX_HIGH;
	localparam logic [7:0] A_RL = spe_pkg::OFS_RX_LOW;
	logic sys_clk = 1'h0;
	logic nrst = 1'h0;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic gen_frame_pulse = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata, v, cap;
	logic tx_bit_clock, tx_frame_sync, fs_m, tx_frame_sync_out, tx_frame_sync_oe;
	logic tx_data_line, tx_data_oe, rx_bit_clock, rx_frame_sync, rx_data_line;
	logic tx_irq, rx_irq, tx_dma_event;
	int mismatches = 0;
	int tests_run = 0;
	int n_ti = 0;
	int n_ri = 0;
	int n_dm = 0;
	int n_fo = 0;
	int c0;
	int c1;
	initial
	begin
		forever #10 sys_clk = ~sys_clk;
	end
	// Sync pin level from whichever side drives it
	assign tx_frame_sync = tx_frame_sync_oe ? tx_frame_sync_out : fs_m;
	always @(posedge sys_clk)
	begin
		n_ti <= n_ti + int'(tx_irq);
		n_ri <= n_ri + int'(rx_irq);
		n_dm <= n_dm + int'(tx_dma_event);
	end
	always @(posedge tx_frame_sync_out)
		n_fo++;
	spe_core spe_core_i (
		.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.tx_bit_clock, .tx_frame_sync, .tx_frame_sync_out, .tx_frame_sync_oe,
		.tx_data_line, .tx_data_oe, .gen_frame_pulse, .rx_bit_clock,
		.rx_frame_sync, .rx_data_line, .tx_irq, .rx_irq, .tx_dma_event
	);
	spe_link_model spe_link_model_i (
		.tx_bit_clock, .tx_frame_sync(fs_m), .tx_data_line,
		.rx_bit_clock, .rx_frame_sync, .rx_data_line
	);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h, want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	task automatic t_reset;
		rd(A_ST, v);
		chk(v, 32'h1);
		rd(8'h40, v);
		chk(v, 32'h0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_zeros;
		wr(A_CT, 32'h3);
		rd(A_ST, v);
		chk(v[1:0], 2'h1);
		spe_link_model_i.tx_frame(16, 99, cap);
		chk(cap[15:0], 16'h0);
		$display("zeros test done");
	endtask : t_zeros
	task automatic t_over;
		c0 = n_dm;
		c1 = n_ti;
		wr(A_TL, 32'h1234);
		wr(A_TL, 32'hC35A);
		rd(A_ST, v);
		chk(v[1:0], 2'h3);
		chk(n_dm - c0, 2);
		chk(n_ti - c1, 2);
		spe_link_model_i.tx_frame(16, 99, cap);
		chk(cap[15:0], 16'hC35A);
		rd(A_ST, v);
		chk(v[1], 1'h0);
		spe_link_model_i.tx_frame(16, 99, cap);
		chk(cap[15:0], 16'hC35A);
		$display("overwrite test done");
	endtask : t_over
	task automatic t_delay;
		// Wide words give delays 0 to 2 a full 32-bit check
		for (int d = 0; d < 3; d++)
		begin
			wr(A_CT, 32'h4003 | (d << 4));
			wr(A_TH, 32'hA5F0);
			wr(A_TL, 32'h0F5A + d);
			spe_link_model_i.tx_frame(32 + d, 99, cap);
			chk(cap, 32'hA5F00F5A + d);
		end
		rd(A_ST, v);
		chk(v[2], 1'h0);
		$display("delay test done");
	endtask : t_delay
	task automatic t_txerr;
		c0 = n_ti;
		wr(A_CT, 32'h0303);
		wr(A_TL, 32'h96E1);
		spe_link_model_i.tx_frame(21, 5, cap);
		chk(cap[15:0], 16'h96E1);
		rd(A_ST, v);
		chk(v[2], 1'h1);
		chk(n_ti - c0, 1);
		wr(A_ST, 32'h0);
		rd(A_ST, v);
		chk(v[2], 1'h0);
		wr(A_CT, 32'h0B03);
		spe_link_model_i.tx_frame(16, 5, cap);
		chk(cap[10:0], 11'h6E1);
		rd(A_ST, v);
		chk(v[2], 1'h0);
		$display("tx sync error test done");
	endtask : t_txerr
	task automatic t_intsync;
		c0 = n_fo;
		wr(A_CT, 32'h1003);
		wr(A_TL, 32'h3C5A);
		spe_link_model_i.tx_frame(16, 99, cap);
		chk(cap[15:0], 16'h3C5A);
		chk(n_fo - c0, 1);
		// Rate generator pacing: a copy alone must not start a frame
		wr(A_CT, 32'h3003);
		wr(A_TL, 32'h7E81);
		spe_link_model_i.tx_frame(16, 99, cap);
		chk(cap[15:0], 16'h0);
		chk(n_fo - c0, 1);
		@(posedge sys_clk);
		gen_frame_pulse <= 1'h1;
		@(posedge sys_clk);
		gen_frame_pulse <= 1'h0;
		spe_link_model_i.tx_frame(16, 99, cap);
		chk(cap[15:0], 16'h7E81);
		chk(n_fo - c0, 2);
		$display("internal sync test done");
	endtask : t_intsync
	task automatic t_rx;
		for (int d = 0; d < 3; d++)
		begin
			wr(A_CT, 32'h0003 | (d << 2));
			spe_link_model_i.rx_frame(16'h5AC3 ^ d[15:0], 0, d);
			rd(A_RL, v);
			chk(v, 32'h5AC3 ^ d);
		end
		c0 = n_ri;
		wr(A_CT, 32'h00C3);
		spe_link_model_i.rx_frame(16'hB2E4, 6, 0);
		rd(A_RL, v);
		chk(v, 32'hB2E4);
		rd(A_ST, v);
		chk(v[4], 1'h1);
		chk(n_ri - c0, 1);
		wr(A_ST, 32'h0);
		rd(A_ST, v);
		chk(v[4], 1'h0);
		// Ignored early sync: word goes on, no flag, no irq
		c0 = n_ri;
		wr(A_CT, 32'h04C3);
		spe_link_model_i.rx_frame(16'hB2E4, 6, 0);
		rd(A_RL, v);
		chk(v[9:0], 10'h2CB);
		rd(A_ST, v);
		chk(v[4], 1'h0);
		chk(n_ri - c0, 0);
		$display("rx test done");
	endtask : t_rx
	initial
	begin
		repeat (4) @(posedge sys_clk);
		nrst <= 1'h1;
		t_reset();
		t_zeros();
		t_over();
		t_delay();
		t_txerr();
		t_intsync();
		t_rx();
		stop_test();
	end
	initial
	begin
		#1000000;
		mismatches++;
		stop_test();
	end
endmodule : tb_spe_core
`default_nettype wire
